/* common/dps_defs.vh */
`ifndef DPS_DEFS_VH
`define DPS_DEFS_VH

// ****************************************************************
// Bus addresses of the two targets (values are arbitrary)
// ****************************************************************
`define DPS_MEM_SADDR 7'h2A
`define DPS_REG_SADDR 7'h3B

// ****************************************************************
// Pointer layout and reset values
// ****************************************************************
`define DPS_MEM_AW 15
`define DPS_REG_AW 5
// Larger density keeps A14..A0; the smaller one would use 15'h1FFF
`define DPS_MEM_MASK 15'h7FFF
`define DPS_MEM_PTR_RST 15'h0000
`define DPS_REG_PTR_RST 5'h00
`define DPS_REG_LAST 8'h18
`define DPS_REG_PAD 10'h000

// ****************************************************************
// Byte framing
// ****************************************************************
`define DPS_BYTE_BITS 4'h8
`define DPS_CNT_RST 4'h0
`define DPS_RW_BIT 0
`define DPS_MSB 7
`define DPS_NEXT_MSB 6

// ****************************************************************
// Write FIFO shape: {target, address, data}
// ****************************************************************
`define DPS_FIFO_W 24
`define DPS_FIFO_D 16
`define DPS_FIFO_AW 4
`define DPS_WF_REG 23
`define DPS_WF_ADR_HI 22
`define DPS_WF_ADR_LO 8
`define DPS_WF_DAT_HI 7
`define DPS_WF_DAT_LO 0

`endif

/* core/dps_fifo.v */
`timescale 1ns/1ps
`include "dps_defs.vh"

// ****************************************************************
// Synchronous FIFO with valid/ready on both sides
// ****************************************************************
module dps_fifo #(
    parameter W = `DPS_FIFO_W,
    parameter D = `DPS_FIFO_D,
    parameter AW = `DPS_FIFO_AW
) (
    input wire clk_i, // Clock
    input wire reset_n_i, // Asynchronous reset, active low
    input wire in_valid_i, // Word offered
    output wire in_ready_o, // Room for a word
    input wire [W-1:0] in_data_i, // Word in
    output wire out_valid_o, // Word available
    input wire out_ready_i, // Consumer takes the word
    output wire [W-1:0] out_data_o // Oldest word
);

    reg [W-1:0] mem [0:D-1];
    reg [AW-1:0] wptr_reg;
    reg [AW-1:0] rptr_reg;
    reg [AW:0] count_reg;
    wire push;
    wire pop;

    // Honest flags straight from the occupancy count
    assign in_ready_o = (count_reg != D[AW:0]);
    assign out_valid_o = (count_reg != {(AW+1){1'b0}});
    assign out_data_o = mem[rptr_reg];
    assign push = in_valid_i & in_ready_o;
    assign pop = out_valid_o & out_ready_i;

    // Storage needs no reset; only the pointers define content
    always @(posedge clk_i) begin
        if (push) begin
            mem[wptr_reg] <= in_data_i;
        end
    end

    // Pointers wrap naturally because the depth is a power of two
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wptr_reg <= {AW{1'b0}};
            rptr_reg <= {AW{1'b0}};
            count_reg <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wptr_reg <= wptr_reg + {{(AW-1){1'b0}}, 1'b1};
            end
            if (pop) begin
                rptr_reg <= rptr_reg + {{(AW-1){1'b0}}, 1'b1};
            end
            if (push && !pop) begin
                count_reg <= count_reg + {{AW{1'b0}}, 1'b1};
            end else if (pop && !push) begin
                count_reg <= count_reg - {{AW{1'b0}}, 1'b1};
            end
        end
    end

endmodule // dps_fifo

/* core/dps_i2c_slave.v */
// Overview of operation
// - After a read address, data from the current pointer starts next clock.
// - Register pointer advances after every byte, like the memory pointer.
// - Two pointers: memory and register; the bus address picks which one.
// - Loading or advancing one pointer never touches the other.
// - Memory read after register traffic resumes after the last memory byte.
// - Memory address is two bytes, high first; top address bit ignored.
// - Register write: start, address, register byte, data, stop; each acked.
// - Register address above 18h is not acknowledged and the transfer ends.
// - Memory pointer increments before the ack and wraps 7FFFh to 0000h.
// - Reads continue only on master ack; no ack ends; MSB first.
`timescale 1ns/1ps
`include "dps_defs.vh"

module dps_i2c_slave (
    input wire CLK_I, // 200 MHz system clock
    input wire RESET_N_I, // Asynchronous reset, active low
    input wire SCL_I, // Serial clock level
    input wire SDA_I, // Serial data level
    output wire SDA_O, // Serial data drive value, always low
    output wire SDA_OE_O, // High while pulling data low
    output wire [14:0] RD_ADDR_O, // Address of the byte to send
    output wire RD_REG_O, // High when the read targets registers
    input wire [7:0] RD_DATA_I, // Byte at RD_ADDR_O
    output wire WR_VALID_O, // Write word available
    input wire WR_READY_I, // Consumer takes the write word
    output wire WR_REG_O, // Write word targets registers
    output wire [14:0] WR_ADDR_O, // Write address
    output wire [7:0] WR_DATA_O, // Write data
    output wire [14:0] MEM_PTR_O, // Memory pointer
    output wire [4:0] REG_PTR_O // Register pointer
);

    // ****************************************************************
    // States and stages
    // ****************************************************************
    localparam ST_IDLE = 3'h0;
    localparam ST_RX = 3'h1;
    localparam ST_RXACK = 3'h2;
    localparam ST_TX = 3'h3;
    localparam ST_TXACK = 3'h4;

    localparam SG_SADDR = 3'h0;
    localparam SG_MADRH = 3'h1;
    localparam SG_MADRL = 3'h2;
    localparam SG_RADR = 3'h3;
    localparam SG_WDATA = 3'h4;

    // ****************************************************************
    // Declarations
    // ****************************************************************
    reg scl_reg;
    reg scl_d_reg;
    reg sda_reg;
    reg sda_d_reg;
    reg [2:0] state_reg;
    reg [2:0] stage_reg;
    reg [3:0] cnt_reg;
    reg [7:0] shift_reg;
    reg sda_oe_reg;
    reg sel_reg_reg;
    reg read_reg;
    reg [6:0] adr_hi_reg;
    reg [14:0] mem_ptr_reg;
    reg [4:0] reg_ptr_reg;
    reg [14:0] rd_addr_reg;
    reg rd_reg_reg;

    wire scl_rise;
    wire scl_fall;
    wire start_det;
    wire stop_det;
    wire [14:0] mem_ptr_next;
    wire [4:0] reg_ptr_next;
    wire byte_done;
    wire addr_mem;
    wire addr_reg;
    wire fifo_in_ready;
    wire wr_push;
    wire [14:0] cur_addr;
    wire [`DPS_FIFO_W-1:0] fifo_out;

    // ****************************************************************
    // Line sampling and bus conditions
    // ****************************************************************

    // Inputs are synchronous, one stage gives the edge history
    always @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            scl_reg <= 1'b1;
            scl_d_reg <= 1'b1;
            sda_reg <= 1'b1;
            sda_d_reg <= 1'b1;
        end else begin
            scl_reg <= SCL_I;
            scl_d_reg <= scl_reg;
            sda_reg <= SDA_I;
            sda_d_reg <= sda_reg;
        end
    end

    // Edges and start/stop, seen one sample after the line moves
    assign scl_rise = scl_reg & ~scl_d_reg;
    assign scl_fall = ~scl_reg & scl_d_reg;
    assign start_det = scl_reg & scl_d_reg & sda_d_reg & ~sda_reg;
    assign stop_det = scl_reg & scl_d_reg & ~sda_d_reg & sda_reg;
    assign byte_done = scl_fall && (cnt_reg == `DPS_BYTE_BITS);

    assign addr_mem = (shift_reg[7:1] == `DPS_MEM_SADDR);
    assign addr_reg = (shift_reg[7:1] == `DPS_REG_SADDR);

    // ****************************************************************
    // Pointer arithmetic
    // ****************************************************************

    assign mem_ptr_next = (mem_ptr_reg + 15'h0001) & `DPS_MEM_MASK;

    // Register pointer wrap past last
    // Widen the pointer rather than slice the last-address constant
    assign reg_ptr_next = ({3'h0, reg_ptr_reg} == `DPS_REG_LAST) ? `DPS_REG_PTR_RST : reg_ptr_reg + 5'h01;

    assign cur_addr = sel_reg_reg ? {`DPS_REG_PAD, reg_ptr_reg} : mem_ptr_reg;

    assign wr_push = (state_reg == ST_RX) && byte_done && (stage_reg == SG_WDATA) && fifo_in_ready;

    // ****************************************************************
    // Byte engine
    // ****************************************************************

    // Start and stop override any state; start may be a repeated one
    always @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            state_reg <= ST_IDLE;
            stage_reg <= SG_SADDR;
            cnt_reg <= `DPS_CNT_RST;
            shift_reg <= 8'h00;
            sda_oe_reg <= 1'b0;
            sel_reg_reg <= 1'b0;
            read_reg <= 1'b0;
            adr_hi_reg <= 7'h00;
            mem_ptr_reg <= `DPS_MEM_PTR_RST;
            reg_ptr_reg <= `DPS_REG_PTR_RST;
        end else if (start_det) begin
            state_reg <= ST_RX;
            stage_reg <= SG_SADDR;
            cnt_reg <= `DPS_CNT_RST;
            sda_oe_reg <= 1'b0;
        end else if (stop_det) begin
            state_reg <= ST_IDLE;
            sda_oe_reg <= 1'b0;
        end else begin
            case (state_reg)
                ST_RX: begin
                    if (scl_rise) begin
                        shift_reg <= {shift_reg[6:0], sda_reg};
                        cnt_reg <= cnt_reg + 4'h1;
                    end else if (byte_done) begin
                        cnt_reg <= `DPS_CNT_RST;
                        case (stage_reg)
                            SG_SADDR: begin
                                if (addr_mem || addr_reg) begin
                                    sel_reg_reg <= addr_reg;
                                    read_reg <= shift_reg[`DPS_RW_BIT];
                                    stage_reg <= addr_reg ? SG_RADR : SG_MADRH;
                                    state_reg <= ST_RXACK;
                                    sda_oe_reg <= 1'b1;
                                end else begin
                                    state_reg <= ST_IDLE;
                                end
                            end
                            SG_MADRH: begin
                                // High address byte first, top bit dropped
                                adr_hi_reg <= shift_reg[6:0];
                                stage_reg <= SG_MADRL;
                                state_reg <= ST_RXACK;
                                sda_oe_reg <= 1'b1;
                            end
                            SG_MADRL: begin
                                mem_ptr_reg <= {adr_hi_reg, shift_reg} & `DPS_MEM_MASK;
                                stage_reg <= SG_WDATA;
                                state_reg <= ST_RXACK;
                                sda_oe_reg <= 1'b1;
                            end
                            SG_RADR: begin
                                if (shift_reg <= `DPS_REG_LAST) begin
                                    reg_ptr_reg <= shift_reg[4:0];
                                    stage_reg <= SG_WDATA;
                                    state_reg <= ST_RXACK;
                                    sda_oe_reg <= 1'b1;
                                end else begin
                                    state_reg <= ST_IDLE;
                                end
                            end
                            SG_WDATA: begin
                                // A full FIFO refuses the byte rather than lose it
                                if (fifo_in_ready) begin
                                    if (sel_reg_reg) begin
                                        reg_ptr_reg <= reg_ptr_next;
                                    end else begin
                                        mem_ptr_reg <= mem_ptr_next;
                                    end
                                    state_reg <= ST_RXACK;
                                    sda_oe_reg <= 1'b1;
                                end else begin
                                    state_reg <= ST_IDLE;
                                end
                            end
                            default: begin
                                state_reg <= ST_IDLE;
                            end
                        endcase
                    end
                end
                ST_RXACK: begin
                    if (scl_fall) begin
                        if (read_reg) begin
                            // First data bit right after the address ack
                            state_reg <= ST_TX;
                            shift_reg <= RD_DATA_I;
                            sda_oe_reg <= ~RD_DATA_I[`DPS_MSB];
                        end else begin
                            state_reg <= ST_RX;
                            sda_oe_reg <= 1'b0;
                        end
                    end
                end
                ST_TX: begin
                    if (scl_rise) begin
                        cnt_reg <= cnt_reg + 4'h1;
                    end else if (byte_done) begin
                        cnt_reg <= `DPS_CNT_RST;
                        sda_oe_reg <= 1'b0;
                        state_reg <= ST_TXACK;
                        if (sel_reg_reg) begin
                            reg_ptr_reg <= reg_ptr_next;
                        end else begin
                            mem_ptr_reg <= mem_ptr_next;
                        end
                    end else if (scl_fall) begin
                        shift_reg <= {shift_reg[6:0], 1'b0};
                        sda_oe_reg <= ~shift_reg[`DPS_NEXT_MSB];
                    end
                end
                ST_TXACK: begin
                    // No master ack ends the read
                    if (scl_rise && sda_reg) begin
                        state_reg <= ST_IDLE;
                    end else if (scl_fall) begin
                        state_reg <= ST_TX;
                        shift_reg <= RD_DATA_I;
                        sda_oe_reg <= ~RD_DATA_I[`DPS_MSB];
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                    sda_oe_reg <= 1'b0;
                end
            endcase
        end
    end

    // ****************************************************************
    // Read address to the storage side
    // ****************************************************************

    // Registered so the port is glitch free; storage answers within a cycle
    always @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            rd_addr_reg <= `DPS_MEM_PTR_RST;
            rd_reg_reg <= 1'b0;
        end else begin
            rd_addr_reg <= cur_addr;
            rd_reg_reg <= sel_reg_reg;
        end
    end

    // ****************************************************************
    // Write FIFO between the serial side and storage
    // ****************************************************************
    dps_fifo #(
        .W(`DPS_FIFO_W),
        .D(`DPS_FIFO_D),
        .AW(`DPS_FIFO_AW)
    ) u_wr_fifo (
        .clk_i(CLK_I),
        .reset_n_i(RESET_N_I),
        .in_valid_i(wr_push),
        .in_ready_o(fifo_in_ready),
        .in_data_i({sel_reg_reg, cur_addr, shift_reg}),
        .out_valid_o(WR_VALID_O),
        .out_ready_i(WR_READY_I),
        .out_data_o(fifo_out)
    );

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign SDA_O = 1'b0;
    assign SDA_OE_O = sda_oe_reg;
    assign RD_ADDR_O = rd_addr_reg;
    assign RD_REG_O = rd_reg_reg;
    assign WR_REG_O = fifo_out[`DPS_WF_REG];
    assign WR_ADDR_O = fifo_out[`DPS_WF_ADR_HI:`DPS_WF_ADR_LO];
    assign WR_DATA_O = fifo_out[`DPS_WF_DAT_HI:`DPS_WF_DAT_LO];
    assign MEM_PTR_O = mem_ptr_reg;
    assign REG_PTR_O = reg_ptr_reg;

endmodule // dps_i2c_slave

/* tb/dps_i2c_slave_sva.sv */
`timescale 1ns/1ps
// ************************************************************
// Port checker for the serial slave
// ************************************************************
module dps_i2c_slave_sva (
    input wire CLK_I, // Clock
    input wire RESET_N_I, // Reset, active low
    input wire SCL_I, // Serial clock
    input wire SDA_OE_O, // Data pull-down
    input wire WR_VALID_O, // Write word held
    input wire WR_READY_I, // Word taken
    input wire WR_REG_O, // Word targets registers
    input wire [14:0] WR_ADDR_O, // Word address
    input wire [7:0] WR_DATA_O, // Word data
    input wire [14:0] MEM_PTR_O, // Memory pointer
    input wire [4:0] REG_PTR_O // Register pointer
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RESET_N_I);
    // A pulled bit must outlast the SCL rise so the master can sample it
    sequence s_oe_on;
        $rose(SDA_OE_O);
    endsequence
    sequence s_oe_held;
        SDA_OE_O [*4];
    endsequence
    property p_oe_hold;
        s_oe_on |=> s_oe_held;
    endproperty
    a_oe_hold: assert property (p_oe_hold) else $error("data pull-down too short");
    // Data moving with SCL high would read as START or STOP
    property p_oe_scl;
        $changed(SDA_OE_O) |-> !SCL_I;
    endproperty
    a_oe_scl: assert property (p_oe_scl) else $error("data changed with SCL high");
    // Pointers never move together
    property p_iso;
        $changed(MEM_PTR_O) |-> $stable(REG_PTR_O);
    endproperty
    a_iso: assert property (p_iso) else $error("both pointers moved together");
    property p_mem_low;
        $changed(MEM_PTR_O) |-> !SCL_I;
    endproperty
    a_mem_low: assert property (p_mem_low) else $error("memory pointer moved with SCL high");
    property p_reg_max;
        REG_PTR_O <= 5'h18;
    endproperty
    a_reg_max: assert property (p_reg_max) else $error("register pointer out of range");
    // Write word stands until taken
    property p_wr_hold;
        WR_VALID_O && !WR_READY_I |=> WR_VALID_O && $stable({WR_REG_O, WR_ADDR_O, WR_DATA_O});
    endproperty
    a_wr_hold: assert property (p_wr_hold) else $error("write word changed before taken");
    property p_wr_reg;
        WR_VALID_O && WR_REG_O |-> WR_ADDR_O <= 15'h0018;
    endproperty
    a_wr_reg: assert property (p_wr_reg) else $error("illegal register write queued");
    // First queued word sits one behind the advanced pointer
    property p_mem_step;
        $rose(WR_VALID_O) && !WR_REG_O |-> MEM_PTR_O == WR_ADDR_O + 15'h0001;
    endproperty
    a_mem_step: assert property (p_mem_step) else $error("memory pointer step wrong");
    property p_reg_step;
        $rose(WR_VALID_O) && WR_REG_O |->
            REG_PTR_O == ((WR_ADDR_O[4:0] == 5'h18) ? 5'h00 : WR_ADDR_O[4:0] + 5'h01);
    endproperty
    a_reg_step: assert property (p_reg_step) else $error("register pointer step wrong");
endmodule // dps_i2c_slave_sva
bind dps_i2c_slave dps_i2c_slave_sva u_sva (.CLK_I(CLK_I), .RESET_N_I(RESET_N_I), .SCL_I(SCL_I),
    .SDA_OE_O(SDA_OE_O), .WR_VALID_O(WR_VALID_O), .WR_READY_I(WR_READY_I), .WR_REG_O(WR_REG_O),
    .WR_ADDR_O(WR_ADDR_O), .WR_DATA_O(WR_DATA_O), .MEM_PTR_O(MEM_PTR_O), .REG_PTR_O(REG_PTR_O));

/* tb/dps_mst_model.sv */
`timescale 1ns/1ps
// ************************************************************
// Two-wire bus master, moves lines on the falling clock edge
// ************************************************************
module dps_mst_model (
    input wire clk_i, // Bench clock
    input wire sda_i, // Resolved data wire
    output logic scl_o, // Serial clock
    output logic sda_o // Data drive, 1 releases to pull-up
);
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    task automatic wt(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    task automatic start;
        sda_o = 1'b1;
        wt(4);
        scl_o = 1'b1;
        wt(4);
        sda_o = 1'b0;
        wt(4);
        scl_o = 1'b0;
        wt(2);
    endtask
    task automatic stop;
        sda_o = 1'b0;
        wt(4);
        scl_o = 1'b1;
        wt(4);
        sda_o = 1'b1;
        wt(8);
    endtask
    // One bit; data set well before SCL rises, held past its fall
    task automatic bit_x(input logic b, output logic r);
        sda_o = b;
        wt(4);
        scl_o = 1'b1;
        wt(3);
        r = sda_i;
        wt(3);
        scl_o = 1'b0;
        wt(2);
    endtask
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_x(d[i], r);
        bit_x(1'b1, r);
        ack = !r;
    endtask
    task automatic rbyte(input logic ack_m, output logic [7:0] d);
        logic r;
        for (int i = 0; i < 8; i++) begin
            bit_x(1'b1, r);
            d = {d[6:0], r};
        end
        bit_x(!ack_m, r);
    endtask
endmodule // dps_mst_model

/* tb/testbench.sv */
`timescale 1ns/1ps
`include "dps_defs.vh"
module testbench;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic wr_ready = 1'b0;
    logic stall = 1'b0;
    wire scl, sda_m, sda_w, sda_o, sda_oe, rd_reg, wr_valid, wr_reg;
    wire [14:0] rd_addr, wr_addr, mem_ptr;
    wire [7:0] wr_data, rd_data;
    wire [4:0] reg_ptr;
    logic [7:0] mem [0:32767];
    logic [7:0] emem [0:32767];
    logic [7:0] regs [0:31];
    logic [7:0] ereg [0:31];
    logic [14:0] ptr [0:1];
    int error_cnt = 0;
    int checks = 0;
    always #2.5 clk = ~clk;
    // Wire level: device pull-down wins over master
    assign sda_w = sda_oe ? sda_o : sda_m;
    assign rd_data = rd_reg ? regs[rd_addr[4:0]] : mem[rd_addr];
    dps_mst_model mst (.clk_i(clk), .sda_i(sda_w), .scl_o(scl), .sda_o(sda_m));
    dps_i2c_slave dut (.CLK_I(clk), .RESET_N_I(rst_n), .SCL_I(scl), .SDA_I(sda_w), .SDA_O(sda_o),
        .SDA_OE_O(sda_oe), .RD_ADDR_O(rd_addr), .RD_REG_O(rd_reg), .RD_DATA_I(rd_data),
        .WR_VALID_O(wr_valid), .WR_READY_I(wr_ready), .WR_REG_O(wr_reg), .WR_ADDR_O(wr_addr),
        .WR_DATA_O(wr_data), .MEM_PTR_O(mem_ptr), .REG_PTR_O(reg_ptr));
    // Storage drains the write queue with random stalls
    always @(negedge clk) wr_ready <= !stall && ($urandom % 3 != 0);
    always @(posedge clk) begin
        if (wr_valid && wr_ready) begin
            if (wr_reg) regs[wr_addr[4:0]] <= wr_data;
            else mem[wr_addr] <= wr_data;
        end
    end
    function automatic logic [14:0] nxt(input int t, input logic [14:0] p);
        return (t != 0 && p[4:0] == 5'h18) ? 15'h0000 : p + 15'h0001;
    endfunction
    task automatic fail(input string m);
        error_cnt++;
        $display("[FAIL] %0t %s", $time, m);
    endtask
    task automatic chk1(input logic g, input logic e);
        checks++;
        if (g !== e) fail($sformatf("flag got %b exp %b", g, e));
    endtask
    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        checks++;
        if (g !== e) fail($sformatf("byte got %h exp %h", g, e));
    endtask
    task automatic chk15(input logic [14:0] g, input logic [14:0] e);
        checks++;
        if (g !== e) fail($sformatf("pointer got %h exp %h", g, e));
    endtask
    task automatic chkp;
        chk15(mem_ptr, ptr[0]);
        chk15({10'h000, reg_ptr}, ptr[1]);
    endtask
    task automatic conclude;
        $display("Mismatches %0d, checks %0d", error_cnt, checks);
        if (error_cnt == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic drain;
        int n;
        n = 0;
        while (wr_valid !== 1'b0 && n < 3000) begin
            @(negedge clk);
            n++;
        end
        if (n == 3000) begin
            fail("queue never drained");
            conclude();
        end
    endtask
    // Write n bytes at a; only the first lim are expected to be taken
    task automatic wr(input int t, input logic [14:0] a, input int n, input int lim);
        logic ack;
        logic [7:0] d;
        mst.start();
        mst.wbyte({(t != 0) ? `DPS_REG_SADDR : `DPS_MEM_SADDR, 1'b0}, ack);
        chk1(ack, 1'b1);
        if (t == 0) begin
            mst.wbyte({1'($urandom), a[14:8]}, ack);
            chk1(ack, 1'b1);
        end
        mst.wbyte(a[7:0], ack);
        chk1(ack, 1'b1);
        ptr[t] = a;
        for (int i = 0; i < n; i++) begin
            d = 8'($urandom);
            mst.wbyte(d, ack);
            chk1(ack, i < lim);
            if (ack === 1'b1) begin
                if (t != 0) ereg[ptr[1][4:0]] = d;
                else emem[ptr[0]] = d;
                ptr[t] = nxt(t, ptr[t]);
            end
        end
        mst.stop();
        stall = 1'b0;
        drain();
        chkp();
    endtask
    task automatic rd(input int t, input int n);
        logic ack;
        logic [7:0] d;
        mst.start();
        mst.wbyte({(t != 0) ? `DPS_REG_SADDR : `DPS_MEM_SADDR, 1'b1}, ack);
        chk1(ack, 1'b1);
        chk1(rd_reg, t != 0);
        chk15(rd_addr, ptr[t]);
        for (int i = 0; i < n; i++) begin
            mst.rbyte(i < n - 1, d);
            chk8(d, (t != 0) ? ereg[ptr[1][4:0]] : emem[ptr[0]]);
            ptr[t] = nxt(t, ptr[t]);
        end
        mst.stop();
        chkp();
    endtask
    initial begin
        logic ack;
        int n;
        void'($urandom(62167));
        for (int i = 0; i < 32768; i++) begin
            mem[i] = 8'(i ^ (i >> 7));
            emem[i] = mem[i];
        end
        for (int i = 0; i < 32; i++) begin
            regs[i] = 8'(i * 3);
            ereg[i] = regs[i];
        end
        ptr[0] = 15'h0000;
        ptr[1] = 15'h0000;
        repeat (10) @(negedge clk);
        chkp();
        chk1(sda_oe, 1'b0);
        chk1(sda_o, 1'b0);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        wr(0, 15'h7FFE, 3, 3);
        rd(0, 2);
        wr(0, 15'h7FFF, 0, 0);
        rd(0, 3);
        wr(1, 15'h0017, 3, 3);
        rd(1, 2);
        rd(0, 1);
        wr(1, 15'h0018, 0, 0);
        rd(1, 3);
        // Unknown bus address is ignored
        mst.start();
        mst.wbyte(8'h20, ack);
        chk1(ack, 1'b0);
        mst.stop();
        // Register address past the last one is refused
        mst.start();
        mst.wbyte({`DPS_REG_SADDR, 1'b0}, ack);
        mst.wbyte(8'h19, ack);
        chk1(ack, 1'b0);
        mst.stop();
        chkp();
        // Full queue refuses the seventeenth byte
        stall = 1'b1;
        wr(0, 15'h1234, 17, 16);
        for (int k = 0; k < 30; k++) begin
            n = 1 + $urandom % 4;
            if ($urandom % 2) wr(k % 2, (k % 2) ? 15'($urandom % 25) : 15'($urandom), n, n);
            else rd(k % 2, n);
        end
        conclude();
    end
    initial begin
        repeat (95000) @(posedge clk);
        fail("run timed out");
        conclude();
    end
endmodule // testbench
